// ---- common/gppr_pkg.sv ----
// Shared constants and types for the parallel poll response link
package gppr_pkg;

    // ==========================================================
    // Parallel poll function subsets
    typedef enum logic [1:0] {
        SUB_PP0,
        SUB_PP1,
        SUB_PP2
    } gppr_subset_e;

    // ==========================================================
    // Command bytes, bit 8 already dropped
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_PPC = 7'h05;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_PPU = 7'h15;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [1:0] CMD_LAG_TOP = 2'h1;
    localparam logic [2:0] CMD_PPE_TOP = 3'h6;
    localparam logic [6:0] CMD_PPD = 7'h70;
    localparam logic [1:0] CMD_SCG_TOP = 2'h3;
    localparam int PPE_SENSE_BIT = 3;

    // ==========================================================
    // Controller register map, byte offsets
    localparam logic [7:0] CTL_CMD_OFS = 8'h00;
    localparam logic [7:0] CTL_CTRL_OFS = 8'h04;
    localparam logic [7:0] CTL_STAT_OFS = 8'h08;
    localparam int CMD_ATN_BIT = 8;
    localparam int CTRL_IFC_BIT = 0;
    localparam int CTRL_POLL_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_POLL_LSB = 8;

    // ==========================================================
    // Controller sequencing, cycles per phase
    localparam logic [7:0] SETUP_CYC = 8'h04;
    localparam logic [7:0] STROBE_CYC = 8'h08;
    localparam logic [7:0] HOLD_CYC = 8'h04;
    localparam logic [7:0] POLL_CYC = 8'h10;

    // ==========================================================
    // Device synchroniser after reset: every line released (high)
    localparam logic [11:0] DEV_SYNC_IDLE = 12'hfff;

    // ==========================================================
    // Controller states
    typedef enum logic [2:0] {
        CT_IDLE,
        CT_SETUP,
        CT_STROBE,
        CT_HOLD,
        CT_POLL
    } gppr_ctl_st_e;

endpackage

// ---- common/gppr_if.sv ----
// Open-collector bus between controller and device
`timescale 1ns/1ns
interface gppr_if;
    logic [7:0] dio_n;
    logic [7:0] ctl_dio_o;
    logic [7:0] ctl_dio_oe;
    logic [7:0] dev_dio_o;
    logic [7:0] dev_dio_oe;
    logic atn_n;
    logic eoi_n;
    logic ifc_n;
    logic dav_n;

    // ==========================================================
    // Wired-and: a line is low if any enabled driver pulls it low
    assign dio_n = ~((ctl_dio_oe & ~ctl_dio_o) |
                     (dev_dio_oe & ~dev_dio_o));

    modport ctl (
        output ctl_dio_o,
        output ctl_dio_oe,
        output atn_n,
        output eoi_n,
        output ifc_n,
        output dav_n,
        input dio_n
    );

    modport dev (
        output dev_dio_o,
        output dev_dio_oe,
        input atn_n,
        input eoi_n,
        input ifc_n,
        input dav_n,
        input dio_n
    );
endinterface

// ---- rtl/gppr_controller.sv ----
// Controller end with AHB-Lite register slave
`timescale 1ns/1ns
module gppr_controller (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Bus side
    gppr_if.ctl bus,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import gppr_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        gppr_ctl_st_e fsm;
        logic [7:0] cnt;
        logic [7:0] byte_out;
        logic atn;
        logic ifc;
        logic [7:0] poll;
        logic [7:0] s1;
        logic [7:0] s2;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } gppr_ctl_s;

    gppr_ctl_s st_ff;
    gppr_ctl_s nxt_st;
    logic busy;
    logic cmd_phase;
    logic [31:0] rd_mux;

    assign busy = (st_ff.fsm != CT_IDLE);
    assign cmd_phase = (st_ff.fsm == CT_SETUP) ||
                       (st_ff.fsm == CT_STROBE) ||
                       (st_ff.fsm == CT_HOLD);

    // ==========================================================
    // Read mux, sampled in the address phase
    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            CTL_CMD_OFS: begin
                rd_mux[CMD_ATN_BIT] = st_ff.atn;
                rd_mux[7:0] = st_ff.byte_out;
            end
            CTL_CTRL_OFS: rd_mux[CTRL_IFC_BIT] = st_ff.ifc;
            CTL_STAT_OFS: begin
                rd_mux[STAT_BUSY_BIT] = busy;
                rd_mux[STAT_POLL_LSB +: 8] = st_ff.poll;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = bus.dio_n;
        nxt_st.s2 = st_ff.s1;
        nxt_st.ap_valid = hsel & htrans[1] & hready;
        if (hsel & htrans[1] & hready) begin
            nxt_st.ap_write = hwrite;
            nxt_st.ap_addr = haddr[7:0];
            nxt_st.rdata = rd_mux;
        end
        case (st_ff.fsm)
            CT_IDLE: nxt_st.cnt = 8'h0;
            CT_SETUP: begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
                if (st_ff.cnt == 8'h0) begin
                    nxt_st.fsm = CT_STROBE;
                    nxt_st.cnt = STROBE_CYC - 8'h01;
                end
            end
            CT_STROBE: begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
                if (st_ff.cnt == 8'h0) begin
                    nxt_st.fsm = CT_HOLD;
                    nxt_st.cnt = HOLD_CYC - 8'h01;
                end
            end
            CT_HOLD: begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
                if (st_ff.cnt == 8'h0) begin
                    nxt_st.fsm = CT_IDLE;
                end
            end
            CT_POLL: begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
                if (st_ff.cnt == 8'h0) begin
                    // Any low line means some sharer answers true
                    nxt_st.poll = ~st_ff.s2;
                    nxt_st.fsm = CT_IDLE;
                end
            end
            default: nxt_st.fsm = CT_IDLE;
        endcase
        // Command writes and the poll bit while busy are dropped rather than stalled; the IFC bit still lands
        if (st_ff.ap_valid && st_ff.ap_write) begin
            case (st_ff.ap_addr)
                CTL_CMD_OFS: begin
                    if (!busy) begin
                        nxt_st.byte_out = hwdata[7:0];
                        nxt_st.atn = hwdata[CMD_ATN_BIT];
                        nxt_st.fsm = CT_SETUP;
                        nxt_st.cnt = SETUP_CYC - 8'h01;
                    end
                end
                CTL_CTRL_OFS: begin
                    nxt_st.ifc = hwdata[CTRL_IFC_BIT];
                    if (hwdata[CTRL_POLL_BIT] && !busy) begin
                        nxt_st.fsm = CT_POLL;
                        nxt_st.cnt = POLL_CYC - 8'h01;
                    end
                end
                default: nxt_st.ifc = st_ff.ifc;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign bus.ctl_dio_o = ~st_ff.byte_out;
    assign bus.ctl_dio_oe = cmd_phase ? 8'hff : 8'h00;
    assign bus.atn_n = ~((cmd_phase & st_ff.atn) |
                         (st_ff.fsm == CT_POLL));
    assign bus.eoi_n = ~(st_ff.fsm == CT_POLL);
    assign bus.dav_n = ~(st_ff.fsm == CT_STROBE);
    assign bus.ifc_n = ~st_ff.ifc;
endmodule

// ---- rtl/gppr_device.sv ----
// Device end: parallel poll response, clear and trigger
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Summary of operation
// - Identify message gets one response per device
// - Respond true when status equals sense
// - Unconfigured device never drives response lines
// - Enable byte carries sense and line number
// - Data line 8 ignored in commands
// - True response pulls line n low
// - Low line means some sharer answers true
// - Remote or local configuration; subset zero silent
// - Sense bit held per device
// - Only the controller starts a poll
// - Interface clear line clears every device
// - Device clear all; selected clear listener only
// - Group trigger starts addressed capable device
module gppr_device (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Bus side
    gppr_if.dev bus,
    // Local status and configuration
    input wire logic ist,
    input wire gppr_pkg::gppr_subset_e pp_subset,
    input wire logic loc_cfg_en,
    input wire logic [2:0] loc_line,
    input wire logic loc_sense,
    input wire logic trig_cap,
    input wire logic [4:0] listen_addr,
    // Events
    output logic dev_clear,
    output logic ifc_clear,
    output logic dev_trigger,
    // State
    output logic listening,
    output logic cfg_valid,
    output logic [2:0] cfg_line,
    output logic [2:0] rem_line,
    output logic cfg_sense
);
    import gppr_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [11:0] s1;
        logic [11:0] s2;
        logic dav_prev;
        logic ifc_prev;
        logic listen;
        logic armed;
        logic rem_en;
        logic [2:0] rem_line;
        logic rem_sense;
        logic [7:0] resp_oe;
        logic clr;
        logic ifc_p;
        logic trg;
    } gppr_dev_s;

    gppr_dev_s st_ff;
    gppr_dev_s nxt_st;

    logic [7:0] dio_t;
    logic atn;
    logic eoi;
    logic ifc;
    logic strobe;
    logic idy;
    logic [6:0] cmd;
    logic sel_en;
    logic [2:0] sel_line;
    logic sel_sense;

    // ==========================================================
    // Helpers
    function automatic logic is_secondary(input logic [6:0] c);
        is_secondary = (c[6:5] == CMD_SCG_TOP);
    endfunction

    function automatic logic [7:0] line_onehot(input logic [2:0] n);
        line_onehot = 8'h01 << n;
    endfunction

    // ==========================================================
    // Synchronised bus view, true-active
    assign dio_t = ~st_ff.s2[11:4];
    assign atn = ~st_ff.s2[3];
    assign eoi = ~st_ff.s2[2];
    assign ifc = ~st_ff.s2[1];
    assign strobe = ~st_ff.s2[0] & st_ff.dav_prev;
    // Identify is ATN and EOI both true
    assign idy = atn & eoi;
    // Bit 8 never reaches the decoder
    assign cmd = dio_t[6:0];

    // ==========================================================
    // Active configuration
    always_comb begin
        sel_en = 1'b0;
        sel_line = 3'h0;
        sel_sense = 1'b0;
        case (pp_subset)
            SUB_PP1: begin
                sel_en = st_ff.rem_en;
                sel_line = st_ff.rem_line;
                sel_sense = st_ff.rem_sense;
            end
            SUB_PP2: begin
                sel_en = loc_cfg_en;
                sel_line = loc_line;
                sel_sense = loc_sense;
            end
            default: begin
                sel_en = 1'b0;
                sel_line = 3'h0;
                sel_sense = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {bus.dio_n, bus.atn_n, bus.eoi_n,
                     bus.ifc_n, bus.dav_n};
        nxt_st.s2 = st_ff.s1;
        nxt_st.dav_prev = st_ff.s2[0];
        nxt_st.ifc_prev = ifc;
        nxt_st.clr = 1'b0;
        nxt_st.ifc_p = 1'b0;
        nxt_st.trg = 1'b0;

        if (ifc) begin
            // Interface clear drops addressing and the PPC arm;
            // the poll configuration survives
            nxt_st.listen = 1'b0;
            nxt_st.armed = 1'b0;
            nxt_st.ifc_p = ~st_ff.ifc_prev;
        end else if (strobe && atn) begin
            if (!is_secondary(cmd)) begin
                nxt_st.armed = 1'b0;
            end
            if (cmd[6:5] == CMD_LAG_TOP) begin
                if (cmd == CMD_UNL) begin
                    nxt_st.listen = 1'b0;
                end else if (cmd[4:0] == listen_addr) begin
                    nxt_st.listen = 1'b1;
                end
            end
            case (cmd)
                CMD_PPC: nxt_st.armed = st_ff.listen;
                CMD_PPU: nxt_st.rem_en = 1'b0;
                CMD_DCL: nxt_st.clr = 1'b1;
                CMD_SDC: nxt_st.clr = st_ff.listen;
                CMD_GET: begin
                    nxt_st.trg = st_ff.listen & trig_cap;
                end
                default: nxt_st.clr = 1'b0;
            endcase
            if (st_ff.armed && cmd[6:4] == CMD_PPE_TOP) begin
                nxt_st.rem_en = 1'b1;
                nxt_st.rem_line = cmd[2:0];
                nxt_st.rem_sense = cmd[PPE_SENSE_BIT];
            end else if (st_ff.armed && cmd == CMD_PPD) begin
                nxt_st.rem_en = 1'b0;
            end
        end

        // One line, only during identify, only if configured
        nxt_st.resp_oe = 8'h00;
        if (idy && sel_en) begin
            if (ist == sel_sense) begin
                nxt_st.resp_oe = line_onehot(sel_line);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Idle lines are high; zeros here would fake IFC after reset
            st_ff <= '0;
            st_ff.s1 <= DEV_SYNC_IDLE;
            st_ff.s2 <= DEV_SYNC_IDLE;
            st_ff.dav_prev <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // Open collector: only ever pull low, never drive high
    assign bus.dev_dio_o = 8'h00;
    assign bus.dev_dio_oe = st_ff.resp_oe;
    assign dev_clear = st_ff.clr;
    assign ifc_clear = st_ff.ifc_p;
    assign dev_trigger = st_ff.trg;
    assign listening = st_ff.listen;
    assign cfg_valid = sel_en;
    assign cfg_line = sel_line;
    assign cfg_sense = sel_sense;
    assign rem_line = st_ff.rem_line;
endmodule

// ---- verification/gppr_assertions.sv ----
// Concurrent checks on the parallel poll bus lines
`timescale 1ns/1ns
module gppr_assertions (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus lines
    input wire logic [7:0] ctl_dio_oe,
    input wire logic [7:0] dev_dio_o,
    input wire logic [7:0] dev_dio_oe,
    input wire logic atn_n,
    input wire logic eoi_n,
    input wire logic ifc_n,
    input wire logic dav_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Cycles since identify ended; device lags it through three flops
    logic [3:0] idle_ff;
    logic [3:0] nxt_idle;
    always_comb begin
        nxt_idle = (idle_ff == 4'hf) ? idle_ff : idle_ff + 4'h1;
        if (!atn_n && !eoi_n) begin
            nxt_idle = 4'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_ff <= 4'hf;
        end else begin
            idle_ff <= nxt_idle;
        end
    end

    // ==========================================================
    // Assertions
    one_line_a: assert property ($onehot0(dev_dio_oe))
        else $error("device drives several lines");
    pull_low_a:
        assert property ((dev_dio_oe & dev_dio_o) == 8'h00)
        else $error("device drives a line high");
    no_idle_drive_a:
        assert property (dev_dio_oe != 8'h00 |-> idle_ff < 4'h6)
        else $error("device drives outside identify");
    hold_drive_a:
        assert property (dev_dio_oe != 8'h00 && !eoi_n && !atn_n
            |=> $stable(dev_dio_oe) || eoi_n)
        else $error("response dropped during identify");
    strobe_len_a:
        assert property ($fell(dav_n) |-> !dav_n [*8] ##1 dav_n)
        else $error("strobe length wrong");
    cmd_driven_a:
        assert property (!dav_n |-> ctl_dio_oe == 8'hff)
        else $error("byte not driven under strobe");
    poll_len_a:
        assert property ($fell(eoi_n) |-> (!eoi_n && !atn_n) [*8])
        else $error("identify too short");
    poll_free_a:
        assert property (!eoi_n && !$past(eoi_n) |-> ctl_dio_oe == 8'h00)
        else $error("controller drives data during poll");
    quiet_cmd_a:
        assert property (!dav_n |-> dev_dio_oe == 8'h00)
        else $error("device drives during command");

    cover property (dev_dio_oe != 8'h00);
    cover property ($fell(dav_n) && !atn_n);
    cover property ($fell(ifc_n));
endmodule

// ---- verification/tb_gpib_parallel_poll_response.sv ----
// Self-checking bench for the parallel poll link
`timescale 1ns/1ns
module tb_gpib_parallel_poll_response;
    import gppr_pkg::*;
    // ==========================================================
    // Signals
    logic hclk = 0;
    logic hresetn = 0;
    logic ce = 1;
    logic hsel = 0;
    logic hwrite = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic hreadyout;
    logic ist = 0;
    logic loc_cfg_en = 0;
    logic loc_sense = 0;
    logic trig_cap = 0;
    logic [2:0] loc_line = 0;
    logic [4:0] listen_addr = 5'h05;
    gppr_subset_e pp_subset = SUB_PP1;
    logic dev_clear, ifc_clear, dev_trigger, listening, cfg_valid, cfg_sense;
    logic [2:0] cfg_line, rem_line;
    int fail_count = 0;
    int comparisons = 0;
    int n_clr = 0;
    int n_ifc = 0;
    int n_trg = 0;
    integer seed = 32'h553ec7ed;

    gppr_if gppr_if_i ();
    gppr_controller gppr_controller_i (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .bus(gppr_if_i), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata));
    gppr_device gppr_device_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .bus(gppr_if_i), .ist(ist), .pp_subset(pp_subset),
        .loc_cfg_en(loc_cfg_en), .loc_line(loc_line),
        .loc_sense(loc_sense), .trig_cap(trig_cap),
        .listen_addr(listen_addr), .dev_clear(dev_clear),
        .ifc_clear(ifc_clear), .dev_trigger(dev_trigger),
        .listening(listening), .cfg_valid(cfg_valid),
        .cfg_line(cfg_line), .rem_line(rem_line), .cfg_sense(cfg_sense));
    gppr_assertions gppr_assertions_i (.hclk(hclk), .hresetn(hresetn),
        .ctl_dio_oe(gppr_if_i.ctl_dio_oe), .dev_dio_o(gppr_if_i.dev_dio_o),
        .dev_dio_oe(gppr_if_i.dev_dio_oe), .atn_n(gppr_if_i.atn_n),
        .eoi_n(gppr_if_i.eoi_n), .ifc_n(gppr_if_i.ifc_n),
        .dav_n(gppr_if_i.dav_n));

    // ==========================================================
    // Helpers
    always #2 hclk = ~hclk;
    // Pulses last one cycle, so they are counted rather than sampled
    always @(posedge hclk) begin
        if (dev_clear === 1'b1) n_clr++;
        if (ifc_clear === 1'b1) n_ifc++;
        if (dev_trigger === 1'b1) n_trg++;
    end

    task automatic end_of_test;
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Write, then wait until the controller reports idle
    task automatic run(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        do xfer(CTL_STAT_OFS, 1'b0, 32'h0); while (r[STAT_BUSY_BIT] !== 1'b0);
    endtask

    // Bit 8 of every command byte is random; the device must ignore it
    task automatic cmd(input logic [6:0] c);
        r = $random(seed);
        run(CTL_CMD_OFS, {23'h0, 1'b1, r[0], c});
    endtask

    task automatic poll;
        run(CTL_CTRL_OFS, 32'h2);
    endtask

    function automatic logic [7:0] resp(input logic [2:0] ln,
                                        input logic s, input logic st);
        return (st == s) ? 8'h01 << ln : 8'h00;
    endfunction

    initial begin
        #100000;
        fail_count++;
        end_of_test;
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        poll;
        check(r[15:8], 8'h00);
        // Reset release must not look like the start of IFC
        check(n_ifc, 0);
        cmd({CMD_LAG_TOP, listen_addr});
        for (int i = 0; i < 16; i++) begin
            cmd(CMD_PPC);
            cmd({CMD_PPE_TOP, i[3:0]});
            check(cfg_line, i[2:0]);
            check(rem_line, i[2:0]);
            check(cfg_valid, 1'b1);
            check(cfg_sense, i[PPE_SENSE_BIT]);
            for (int s = 0; s < 2; s++) begin
                ist <= s[0];
                poll;
                check(r[15:8], resp(i[2:0], i[3], s[0]));
            end
        end
        cmd(CMD_PPC);
        cmd(CMD_PPD);
        poll;
        check(r[15:8], 8'h00);
        check(cfg_valid, 1'b0);
        ist <= 1'b0;
        cmd(CMD_PPC);
        cmd(7'h60);
        pp_subset <= SUB_PP0;
        poll;
        check(r[15:8], 8'h00);
        pp_subset <= SUB_PP1;
        poll;
        check(r[15:8], 8'h01);
        // A primary command in between disarms the enable
        trig_cap <= 1'b1;
        cmd(CMD_PPC);
        cmd(CMD_GET);
        cmd(7'h65);
        check(n_trg, 1);
        poll;
        check(r[15:8], 8'h01);
        trig_cap <= 1'b0;
        cmd(CMD_GET);
        check(n_trg, 1);
        cmd(CMD_PPU);
        poll;
        check(r[15:8], 8'h00);
        cmd(CMD_DCL);
        check(n_clr, 1);
        cmd(CMD_SDC);
        check(n_clr, 2);
        cmd(CMD_UNL);
        trig_cap <= 1'b1;
        cmd(CMD_SDC);
        cmd(CMD_GET);
        check(n_clr, 2);
        check(n_trg, 1);
        // Local configuration with random line, sense and status
        pp_subset <= SUB_PP2;
        loc_cfg_en <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            loc_line <= r[2:0];
            loc_sense <= r[3];
            ist <= r[4];
            poll;
            check(r[15:8], resp(loc_line, loc_sense, ist));
        end
        // Remote line outlives local use; the disarmed 0x65 never landed
        check(rem_line, 3'h0);
        loc_cfg_en <= 1'b0;
        poll;
        check(r[15:8], 8'h00);
        cmd({CMD_LAG_TOP, listen_addr});
        check(listening, 1'b1);
        // Clock enable low: the write is lost and IFC stays off
        ce <= 1'b0;
        xfer(CTL_CTRL_OFS, 1'b1, 32'h1);
        repeat (8) @(posedge hclk);
        ce <= 1'b1;
        repeat (8) @(posedge hclk);
        check(gppr_if_i.ifc_n, 1'b1);
        check(n_ifc, 0);
        xfer(CTL_CTRL_OFS, 1'b1, 32'h1);
        repeat (8) @(posedge hclk);
        xfer(CTL_CTRL_OFS, 1'b1, 32'h0);
        check(n_ifc, 1);
        check(listening, 1'b0);
        end_of_test;
    end
endmodule
